/* rtl/msc_defines.vh */
/*
 Constants for the modem status change detector: register byte offsets,
 field positions, reset values and the AXI4-Lite response codes.
 Assumes it is included by bare name from files under rtl/ and test/.
*/
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

// ==========================================================
// Register byte offsets
`define MSC_OFF_MODEM_LINE_STATUS 4'h0
`define MSC_OFF_IRQ_STATUS 4'h4
`define MSC_OFF_IRQ_MASK 4'h8

// ==========================================================
// Modem line status field positions
`define MSC_BIT_DCTS 0
`define MSC_BIT_DDSR 1
`define MSC_BIT_DRI 2
`define MSC_BIT_DCD 3
`define MSC_BIT_CTS 4
`define MSC_BIT_DSR 5
`define MSC_BIT_RI 6
`define MSC_BIT_CD 7

// ==========================================================
// Reset values
`define MSC_DELTA_RST 4'h0
`define MSC_MASK_RST 4'hF
`define MSC_SYNC_RST 4'hF

// ==========================================================
// Bus response codes
`define MSC_RESP_OKAY 2'h0
`define MSC_RESP_SLVERR 2'h2

`endif

/* rtl/msc_sync_edge.v */
/*
 Two-flop synchroniser with edge detection for the four active-low modem
 inputs. Assumes the inputs are asynchronous to clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"

module msc_sync_edge (
    input wire clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    input wire [3:0] pin_n_in,
    output wire [3:0] level_out,
    output wire [3:0] toggle_out,
    output wire [3:0] rise_out
);

    // ==========================================================
    // Synchronisers, one per input
    reg [3:0] meta_reg;
    reg [3:0] sync_reg;
    reg [3:0] prev_reg;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_sync
            // Idle lines rest high, so reset to high to avoid a false edge
            always @(posedge clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                    prev_reg[i] <= 1'b1;
                end else if (ce_in) begin
                    meta_reg[i] <= pin_n_in[i];
                    sync_reg[i] <= meta_reg[i];
                    prev_reg[i] <= sync_reg[i];
                end
            end
            // The second and third flops feed edge logic; the first never does
            assign level_out[i] = ~sync_reg[i];
            assign toggle_out[i] = sync_reg[i] ^ prev_reg[i];
            assign rise_out[i] = sync_reg[i] & ~prev_reg[i];
        end
    endgenerate

endmodule
`default_nettype wire

/* rtl/msc_top.v */
/*
 Modem status change detector with AXI4-Lite register access.
 Assumes the modem pins are asynchronous and active low, one clock.
*/
// The register offsets and register access over AXI4-Lite were left to the implementer.
// Summary of operation
// - Carrier detect changing either way sets its delta flag and requests interrupt.
// - Ring indicator delta flag sets only on 0 to 1 input, requests interrupt.
// - Data set ready changing either way sets bit 1, requests interrupt.
// - Clear to send changing either way sets bit 0, requests interrupt.
// - All four delta flags are zero after reset.
// - Modem status interrupt stays asserted while any of bits 0 to 3 is 1.
// - Reading the modem status register clears all four delta flags.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"

// ==========================================================
// Register map, one aligned 32-bit word each
//   0x0 modem line status: [7:4] live CD, RI, DSR, CTS levels, active high,
//       [3:0] delta flags for CD, RI, DSR, CTS, cleared by reading this word
//   0x4 interrupt status: sticky copy of the same four events, read clears
//   0x8 interrupt mask: [3:0], a 1 lets the matching status bit reach irq_out
// Writes to the two status words answer OKAY and change nothing;
// any other offset answers SLVERR, with zero read data on a read.
//
// Timing
//   A pin change reaches its delta flag on the third enabled edge:
//   two synchroniser flops, then one compare against the previous level.
//   Reads answer one cycle after the address is taken; writes one cycle
//   after both address and data are held.
//   ce_in low freezes every flop, the bus handshakes included, but the
//   ready outputs keep their level, so a handshake made while the enable is low is dropped.
//   A pulse on a pin shorter than one clock period may be missed; the
//   modem lines are slow levels, so no pulse stretching is provided.

module msc_top (
    input wire clk_in,
    input wire sys_rst_in,
    input wire ce_in,
    input wire cts_n_in,
    input wire dsr_n_in,
    input wire ri_n_in,
    input wire cd_n_in,
    output wire modem_irq_out,
    output wire irq_out,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ==========================================================
    // Input synchronisation
    wire [3:0] level;
    wire [3:0] toggle;
    wire [3:0] rise;

    msc_sync_edge u_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .pin_n_in({cd_n_in, ri_n_in, dsr_n_in, cts_n_in}),
        .level_out(level),
        .toggle_out(toggle),
        .rise_out(rise)
    );

    // Events per flag; RI counts only the pin going from 0 to 1
    wire [3:0] delta_evt;
    assign delta_evt[`MSC_BIT_DCTS] = toggle[0];
    assign delta_evt[`MSC_BIT_DDSR] = toggle[1];
    assign delta_evt[`MSC_BIT_DRI] = rise[2];
    assign delta_evt[`MSC_BIT_DCD] = toggle[3];

    // ==========================================================
    // Write channel: address and data accepted in either order
    reg aw_held_reg;
    reg [3:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg [3:0] mask_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] delta_reg;

    // Each half is refused while it is held or a response is pending;
    // this keeps a single write in flight without a counter.
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;

    // Commit once both halves are held; registering first costs a cycle
    // but removes any path from the bus inputs to the mask register.
    wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

    // Hold each half until its partner arrives, then answer
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MSC_RESP_OKAY;
            mask_reg <= `MSC_MASK_RST;
        end else if (ce_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status registers are read-only; only the mask is writable
                if (aw_addr_reg == `MSC_OFF_IRQ_MASK) begin
                    s_axi_bresp <= `MSC_RESP_OKAY;
                    if (w_strb_reg[0])
                        mask_reg <= w_data_reg[3:0];
                end else if (aw_addr_reg == `MSC_OFF_MODEM_LINE_STATUS ||
                             aw_addr_reg == `MSC_OFF_IRQ_STATUS) begin
                    s_axi_bresp <= `MSC_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `MSC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read channel: one read at a time, answered the cycle after
    assign s_axi_arready = ~s_axi_rvalid;
    wire rd_take = s_axi_arvalid & s_axi_arready;
    // Clearing reads act at the edge where the address is taken, so the
    // returned word holds the flags as they stood just before the clear.
    wire rd_mls = rd_take & (s_axi_araddr == `MSC_OFF_MODEM_LINE_STATUS);
    wire rd_ist = rd_take & (s_axi_araddr == `MSC_OFF_IRQ_STATUS);

    // Read data is registered; it stands with rvalid until rready

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `MSC_RESP_OKAY;
        end else if (ce_in) begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MSC_RESP_OKAY;
                case (s_axi_araddr)
                    `MSC_OFF_MODEM_LINE_STATUS: s_axi_rdata <= {24'h0, level, delta_reg};
                    `MSC_OFF_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_stat_reg};
                    `MSC_OFF_IRQ_MASK: s_axi_rdata <= {28'h0, mask_reg};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `MSC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Delta flags: a new event in the read cycle survives the clear.
    // Set wins over clear so that no change is ever lost; the cost is
    // that such an event shows up only on the next read.
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            delta_reg <= `MSC_DELTA_RST;
        end else if (ce_in) begin
            delta_reg <= (rd_mls ? 4'h0 : delta_reg) | delta_evt;
        end
    end

    // Interrupt status: sticky per event, cleared on its own read.
    // It is kept apart from the delta flags so that reading one word
    // does not hide events from software that polls the other.
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_stat_reg <= 4'h0;
        end else if (ce_in) begin
            irq_stat_reg <= (rd_ist ? 4'h0 : irq_stat_reg) | delta_evt;
        end
    end

    // ==========================================================
    // Interrupt outputs
    // Modem request follows the delta flags directly; both outputs are
    // decoded from flops only, so they carry no glitch from the bus.
    assign modem_irq_out = |delta_reg;
    assign irq_out = |(irq_stat_reg & mask_reg);

endmodule
`default_nettype wire

/* test/msc_modem_model.sv */
/* Modem side model driving the four active-low control pins.
 Assumes the bench gives the wanted levels active high. */
`timescale 1ns/100ps
`default_nettype none
module msc_modem_model (
    input wire logic clk_in,
    input wire logic [3:0] level_in,
    output logic [3:0] pin_n_out
);
    // Pins move just after an edge; reset covers the first unknown cycle
    always @(posedge clk_in) pin_n_out <= ~level_in;
endmodule
`default_nettype wire

/* test/msc_top_chk.sv */
/* Port checker for msc_top.
 Assumes ce_in is held high by the bench. */
`timescale 1ns/100ps
`default_nettype none
module msc_top_chk (
    input wire clk_in,
    input wire sys_rst_in,
    input wire cts_n_in,
    input wire dsr_n_in,
    input wire ri_n_in,
    input wire cd_n_in,
    input wire modem_irq_out,
    input wire irq_out,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready
);
    // ====
    // Read of the status word and quiet pins for the clear check
    wire [3:0] pins = {cd_n_in, ri_n_in, dsr_n_in, cts_n_in};
    wire [2:0] tg = {cd_n_in, dsr_n_in, cts_n_in};
    wire rd0 = s_axi_arvalid && s_axi_arready && (s_axi_araddr == 4'h0);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_cd; $changed(cd_n_in) |-> ##[2:4] modem_irq_out; endproperty
    property p_ri; $rose(ri_n_in) |-> ##[2:4] modem_irq_out; endproperty
    property p_dsr; $changed(dsr_n_in) |-> ##[2:4] modem_irq_out; endproperty
    property p_cts; $changed(cts_n_in) |-> ##[2:4] modem_irq_out; endproperty
    property p_rst; disable iff (1'b0) sys_rst_in |=> !modem_irq_out && !irq_out; endproperty
    property p_hold; modem_irq_out && !rd0 |=> modem_irq_out; endproperty
    // Clear only holds when no event is still crossing the synchroniser
    property p_clr;
        rd0 && pins == $past(pins) && pins == $past(pins, 2) && pins == $past(pins, 3)
            |=> !modem_irq_out;
    endproperty
    property p_late; rd0 && tg != $past(tg, 2) |-> ##[1:4] modem_irq_out; endproperty
    a_cd: assert property (p_cd) else $error("cd change lost");
    a_ri: assert property (p_ri) else $error("ri rise lost");
    a_dsr: assert property (p_dsr) else $error("dsr change lost");
    a_cts: assert property (p_cts) else $error("cts change lost");
    a_rst: assert property (p_rst) else $error("irq during reset");
    a_hold: assert property (p_hold) else $error("irq dropped");
    a_clr: assert property (p_clr) else $error("flags not cleared");
    a_late: assert property (p_late) else $error("late change lost");
    c_rd: cover property (rd0 && modem_irq_out);
    c_irq: cover property ($rose(irq_out));
    c_ri: cover property ($fell(ri_n_in));
endmodule
bind msc_top msc_top_chk u_chk (.clk_in, .sys_rst_in, .cts_n_in, .dsr_n_in, .ri_n_in,
    .cd_n_in, .modem_irq_out, .irq_out, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready);
`default_nettype wire

/* test/tb_msc_top.sv */
/* Bench for msc_top: random pin changes, AXI4-Lite reads and writes.
 Assumes the modem model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"
module tb_msc_top;
    logic clk_in = 0, sys_rst_in = 1;
    logic [3:0] lvl = 0, pn, s_axi_awaddr = 0, s_axi_araddr = 0, st = 0, dl = 0, m = 4'hF, nw;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mirq, irq;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int fail_count = 0, n_checks = 0, cyc = 0;
    msc_modem_model u_mdm (.clk_in(clk_in), .level_in(lvl), .pin_n_out(pn));
    msc_top DUT (.clk_in, .sys_rst_in, .ce_in(1'b1), .cts_n_in(pn[0]), .dsr_n_in(pn[1]),
        .ri_n_in(pn[2]), .cd_n_in(pn[3]), .modem_irq_out(mirq), .irq_out(irq), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    initial forever #5 clk_in = ~clk_in;
    // ====
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_sim;
        end
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            fail_count++;
        end
    endtask
    // Read: address held until taken, rready held until rvalid seen
    task rdw(input logic [3:0] a);
        @(posedge clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk_in); while (s_axi_arready !== 1);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1) @(posedge clk_in);
        rdat = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task wrw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    // Ring flag follows the pin rising, which is the level falling
    task step(input logic [3:0] n);
        @(posedge clk_in);
        nw = ((lvl ^ n) & 4'hB) | {1'b0, lvl[2] & ~n[2], 2'b00};
        dl = dl | nw;
        st = st | nw;
        lvl <= n;
        repeat (6) @(posedge clk_in);
        chk("modem_irq", |dl, mirq);
        chk("irq", |(st & m), irq);
    endtask
    initial begin
        void'($urandom(32'h73CDD4D8));
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 0;
        rdw(`MSC_OFF_MODEM_LINE_STATUS);
        chk("mls_rst", 32'h0, rdat);
        rdw(`MSC_OFF_IRQ_MASK);
        chk("mask_rst", 32'hF, rdat);
        rdw(4'hC);
        chk("bad_addr", 32'h0, rdat);
        chk("bad_rresp", {30'h0, `MSC_RESP_SLVERR}, {30'h0, rs});
        wrw(4'hC, 32'h0);
        chk("bad_bresp", {30'h0, `MSC_RESP_SLVERR}, {30'h0, rs});
        wrw(`MSC_OFF_MODEM_LINE_STATUS, 32'hF);
        chk("ro_bresp", {30'h0, `MSC_RESP_OKAY}, {30'h0, rs});
        chk("ro_irq", 0, mirq);
        $display("test reset done");
        repeat (20) begin
            step(4'($urandom));
            if ($urandom % 3 == 0) begin
                rdw(`MSC_OFF_MODEM_LINE_STATUS);
                chk("mls", {24'h0, lvl, dl}, rdat);
                dl = 0;
                chk("mls_clr", 0, mirq);
            end
            if ($urandom % 4 == 0) begin
                m = 4'($urandom);
                wrw(`MSC_OFF_IRQ_MASK, {28'h0, m});
                chk("mask_bresp", {30'h0, `MSC_RESP_OKAY}, {30'h0, rs});
                rdw(`MSC_OFF_IRQ_MASK);
                chk("mask", {28'h0, m}, rdat);
            end
            if ($urandom % 4 == 0) begin
                rdw(`MSC_OFF_IRQ_STATUS);
                chk("irq_st", st, rdat);
                st = 0;
            end
        end
        $display("test random done");
        // Change lands while the clearing read is in flight
        @(posedge clk_in);
        lvl <= lvl ^ 4'h1;
        rdw(`MSC_OFF_MODEM_LINE_STATUS);
        repeat (6) @(posedge clk_in);
        chk("late", 1, mirq);
        rdw(`MSC_OFF_MODEM_LINE_STATUS);
        chk("late_mls", {24'h0, lvl, 4'h1}, rdat);
        $display("test late change done");
        end_sim;
    end
endmodule
`default_nettype wire
